// ### include/pcm_clock_map.vh
/*
 * register map, field positions and timing counts of the clock manager.
 * assumes a 200 MHz system clock; definitions only.
 */
`ifndef PCM_CLOCK_MAP_VH
`define PCM_CLOCK_MAP_VH

// register offsets
`define PCM_ADDR_CTRL 8'h00
`define PCM_ADDR_SYNC 8'h01
`define PCM_ADDR_STAT 8'h02
`define PCM_ADDR_FLAG 8'h03
`define PCM_ADDR_MASK 8'h04

// control fields
`define PCM_CTRL_TRIM_LSB 0
`define PCM_CTRL_SPREAD_EN 4
`define PCM_CTRL_SPAN_SEL 5
`define PCM_CTRL_BAND_SEL 6
`define PCM_CTRL_OUT_EN 7
`define PCM_SYNC_EN_BIT 0

// flag and mask fields
`define PCM_FLAG_SETTLED 0
`define PCM_FLAG_FAULT 1
`define PCM_MASK_RESET 2'h0

// clock rates
`define PCM_MCLK_KHZ 200000
`define PCM_TICK_KHZ 100
`define PCM_TICK_CYC (`PCM_MCLK_KHZ / `PCM_TICK_KHZ)

// trim step dwell, least time rounds up
`define PCM_DWELL_NS 5200
`define PCM_DWELL_CYC ((`PCM_DWELL_NS * (`PCM_MCLK_KHZ / 1000) + 999) / 1000)

// spread modulation, 24 kHz, half period rounds down
`define PCM_SSMOD_HZ 24000
`define PCM_SSMOD_HALF_CYC ((`PCM_MCLK_KHZ * 1000) / (2 * `PCM_SSMOD_HZ))

// accepted sync periods in system cycles
`define PCM_BAND0_FMAX_KHZ 3000
`define PCM_BAND0_FMIN_KHZ 2000
`define PCM_BAND1_FMAX_KHZ 500
`define PCM_BAND1_FMIN_KHZ 333
`define PCM_BAND0_PMIN ((`PCM_MCLK_KHZ + `PCM_BAND0_FMAX_KHZ - 1) / `PCM_BAND0_FMAX_KHZ)
`define PCM_BAND0_PMAX (`PCM_MCLK_KHZ / `PCM_BAND0_FMIN_KHZ)
`define PCM_BAND1_PMIN ((`PCM_MCLK_KHZ + `PCM_BAND1_FMAX_KHZ - 1) / `PCM_BAND1_FMAX_KHZ)
`define PCM_BAND1_PMAX (`PCM_MCLK_KHZ / `PCM_BAND1_FMIN_KHZ)

// valid sync must hold this many 100 kHz ticks
`define PCM_SYNC_DB_TICKS 2

// divider of the high frequency clock
`define PCM_HF_DIV 8

`endif

// ### src/pcm_sync_meter.v
/*
 * period meter of the external sync input: synchronises the pin,
 * measures rising-edge spacing and judges it against the selected band.
 * assumes the pin is asynchronous to clk and clk runs at 200 MHz.
 */
`timescale 1ns/1ps
`include "pcm_clock_map.vh"

module pcm_sync_meter (
   input wire clk,
   input wire rst_n,
   input wire sync_in,
   input wire band_sel,
   output wire sync_lvl,
   output reg period_ok_reg
);

   localparam integer B0_MIN = `PCM_BAND0_PMIN;
   localparam integer B0_MAX = `PCM_BAND0_PMAX;
   localparam integer B1_MIN = `PCM_BAND1_PMIN;
   localparam integer B1_MAX = `PCM_BAND1_PMAX;

   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   reg [10:0] cnt_reg;
   wire rise;
   wire [10:0] per;
   wire [10:0] pmin;
   wire [10:0] pmax;

   assign rise = s2_reg & ~s3_reg;
   assign per = cnt_reg + 11'h001;
   assign pmin = band_sel ? B1_MIN[10:0] : B0_MIN[10:0];
   assign pmax = band_sel ? B1_MAX[10:0] : B0_MAX[10:0];
   assign sync_lvl = s2_reg;

   // two-stage synchroniser, edge taken after the second stage
   always @(posedge clk) begin
      if (!rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= sync_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // period judged at each edge; a stalled pin times out as invalid
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= 11'h000;
         period_ok_reg <= 1'b0;
      end else if (rise) begin
         cnt_reg <= 11'h000;
         period_ok_reg <= (per >= pmin) && (per <= pmax);
      end else begin
         if (cnt_reg != 11'h7ff)
            cnt_reg <= per;
         if (per > pmax)
            period_ok_reg <= 1'b0;
      end
   end

endmodule

// ### src/pcm_clock_mgmt.v
/*
 * digital clock manager: trim walk of the high frequency clock, divide
 * by 8, spread-spectrum control, sync validation with fallback, sync
 * output and interrupt flags behind a plain register port.
 * assumes 200 MHz MCLK, fuse defaults static around reset, and an
 * analog oscillator and pll driven by the outputs.
 */
// Contract
// - control timing derives from a 100 kHz tick; only the sync debounce uses it, dwell and modulation count MCLK
// - 20 MHz clock trimmed by 4-bit field
// - trim codes map to 16..24 MHz steps
// - multi-step change walks, 5.2 us per step
// - settled flag raised, drives irq unless masked
// - switching clock is hf clock divided by 8; code uses the sync pin level in ST_EXT
// - trim loads from fuse default at reset
// - no retuning while spread or sync active
// - spread enable bit, fuse default
// - span bit selects 5 or 10 percent
// - 24 kHz modulation while spread is on
// - sync enabled forces spread off
// - fuse sync off keeps pll off
// - fuse sync on keeps pll running
// - band bit picks accepted sync range
// - out-of-band sync frequency is invalid
// - bad sync reverts internal, sets fault flag
// - fault state follows sync validity
// - return to external needs clear flag, valid
// - sync output low or switching clock
`timescale 1ns/1ps
`include "pcm_clock_map.vh"

module pcm_clock_mgmt (
   input wire MCLK,
   input wire RST_N,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   input wire [3:0] HF_CLOCK_TRIM_FUSE,
   input wire SPREAD_ENABLE_FUSE_DEFAULT,
   input wire SPREAD_SPAN_FUSE_DEFAULT,
   input wire EXT_SYNC_FUSE_ENABLE,
   input wire SYNC_BAND_FUSE_DEFAULT,
   input wire SYNC_CLOCK_OUT_FUSE_DEFAULT,
   input wire HF_CLK_IN,
   input wire EXT_SYNC_IN,
   output reg [3:0] HF_CLOCK_TRIM,
   output reg SPREAD_ON,
   output reg SPREAD_SPAN,
   output reg SPREAD_MOD_UP,
   output reg PLL_ON,
   output reg PLL_SRC_EXT,
   output reg SW_CLK,
   output reg SYNC_CLOCK_OUT,
   output reg TICK_100K,
   output reg IRQ_OUT_N
);

   localparam integer TICK_LAST = `PCM_TICK_CYC - 1;
   localparam integer DWELL_LAST = `PCM_DWELL_CYC - 1;
   localparam integer SSMOD_LAST = `PCM_SSMOD_HALF_CYC - 1;
   localparam integer DB_TICKS = `PCM_SYNC_DB_TICKS;
   localparam integer HF_HALF_LAST = `PCM_HF_DIV / 2 - 1;

   // sync path states
   localparam [1:0] ST_OFF = 2'h0;
   localparam [1:0] ST_INT = 2'h1;
   localparam [1:0] ST_EXT = 2'h2;

   ////////////////////////////////////////////////////////////////////
   // trim code and linear step index (0 = 16 MHz .. 8 = 24 MHz)
   function code_ok;
      input [3:0] c;
      begin
         code_ok = (c <= 4'h4) || ((c >= 4'h9) && (c <= 4'hc));
      end
   endfunction

   function [3:0] idx_of;
      input [3:0] c;
      begin
         if (c <= 4'h4)
            idx_of = c + 4'h4;
         else
            idx_of = c - 4'h9;
      end
   endfunction

   function [3:0] code_of;
      input [3:0] i;
      begin
         if (i >= 4'h4)
            code_of = i - 4'h4;
         else
            code_of = i + 4'h9;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // registers and state
   reg [3:0] trim_reg;
   reg spread_en_reg;
   reg span_reg;
   reg band_reg;
   reg out_en_reg;
   reg sync_en_reg;
   reg [1:0] mask_reg;
   reg settled_flag_reg;
   reg fault_flag_reg;
   reg [3:0] tgt_idx_reg;
   reg [3:0] cur_idx_reg;
   reg [10:0] dwell_reg;
   reg [10:0] tick_cnt_reg;
   reg [12:0] ss_cnt_reg;
   reg hf1_reg;
   reg hf2_reg;
   reg hf3_reg;
   reg [1:0] hf_cnt_reg;
   reg div_reg;
   reg [1:0] db_cnt_reg;
   reg sync_valid_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [3:0] cur_idx_next;
   reg settle_pulse;
   reg sw_clk_next;

   wire sync_en_eff;
   wire spread_act;
   wire hold_walk;
   wire fault_state;
   wire ext_sel;
   wire ext_lvl;
   wire period_ok;
   wire hf_rise;
   wire wr_ctrl;
   wire wr_flag;

   assign sync_en_eff = EXT_SYNC_FUSE_ENABLE & sync_en_reg;
   assign spread_act = spread_en_reg & ~sync_en_eff;
   assign ext_sel = (state_reg == ST_EXT);
   assign hold_walk = spread_act | ext_sel;
   assign fault_state = sync_en_eff & ~sync_valid_reg;
   assign hf_rise = hf2_reg & ~hf3_reg;
   assign wr_ctrl = WR && (ADDR == `PCM_ADDR_CTRL);
   assign wr_flag = WR && (ADDR == `PCM_ADDR_FLAG);

   // period meter of the sync pin
   pcm_sync_meter u_meter (
      .clk(MCLK),
      .rst_n(RST_N),
      .sync_in(EXT_SYNC_IN),
      .band_sel(band_reg),
      .sync_lvl(ext_lvl),
      .period_ok_reg(period_ok)
   );

   ////////////////////////////////////////////////////////////////////
   // 100 kHz control tick from the system clock
   always @(posedge MCLK) begin
      if (!RST_N) begin
         tick_cnt_reg <= 11'h000;
         TICK_100K <= 1'b0;
      end else if (tick_cnt_reg == TICK_LAST[10:0]) begin
         tick_cnt_reg <= 11'h000;
         TICK_100K <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 11'h001;
         TICK_100K <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control register, fuse defaults land on reset
   always @(posedge MCLK) begin
      if (!RST_N) begin
         trim_reg <= HF_CLOCK_TRIM_FUSE;
         tgt_idx_reg <= idx_of(HF_CLOCK_TRIM_FUSE);
         spread_en_reg <= SPREAD_ENABLE_FUSE_DEFAULT;
         span_reg <= SPREAD_SPAN_FUSE_DEFAULT;
         band_reg <= SYNC_BAND_FUSE_DEFAULT;
         out_en_reg <= SYNC_CLOCK_OUT_FUSE_DEFAULT;
         sync_en_reg <= 1'b1;
         mask_reg <= `PCM_MASK_RESET;
      end else if (WR) begin
         if (wr_ctrl) begin
            // bad codes keep the old target so nothing undefined is aimed at
            if (code_ok(WDATA[3:0])) begin
               trim_reg <= WDATA[3:0];
               tgt_idx_reg <= idx_of(WDATA[3:0]);
            end
            spread_en_reg <= WDATA[`PCM_CTRL_SPREAD_EN];
            span_reg <= WDATA[`PCM_CTRL_SPAN_SEL];
            band_reg <= WDATA[`PCM_CTRL_BAND_SEL];
            out_en_reg <= WDATA[`PCM_CTRL_OUT_EN];
         end
         if (ADDR == `PCM_ADDR_SYNC)
            sync_en_reg <= WDATA[`PCM_SYNC_EN_BIT];
         if (ADDR == `PCM_ADDR_MASK)
            mask_reg <= WDATA[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // trim walk: one step at once, then a dwell before the next
   always @* begin
      cur_idx_next = cur_idx_reg;
      settle_pulse = 1'b0;
      if ((dwell_reg == 11'h000) && (cur_idx_reg != tgt_idx_reg) && !hold_walk) begin
         if (cur_idx_reg < tgt_idx_reg)
            cur_idx_next = cur_idx_reg + 4'h1;
         else
            cur_idx_next = cur_idx_reg - 4'h1;
         settle_pulse = (cur_idx_next == tgt_idx_reg);
      end
   end

   // dwell counter; the reset value starts walking-free at the fuse trim
   always @(posedge MCLK) begin
      if (!RST_N) begin
         cur_idx_reg <= idx_of(HF_CLOCK_TRIM_FUSE);
         HF_CLOCK_TRIM <= HF_CLOCK_TRIM_FUSE;
         dwell_reg <= 11'h000;
      end else begin
         cur_idx_reg <= cur_idx_next;
         HF_CLOCK_TRIM <= code_of(cur_idx_next);
         if (cur_idx_next != cur_idx_reg)
            dwell_reg <= DWELL_LAST[10:0];
         else if (dwell_reg != 11'h000)
            dwell_reg <= dwell_reg - 11'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // spread spectrum: level outputs plus 24 kHz up/down direction
   always @(posedge MCLK) begin
      if (!RST_N) begin
         SPREAD_ON <= 1'b0;
         SPREAD_SPAN <= 1'b0;
         SPREAD_MOD_UP <= 1'b0;
         ss_cnt_reg <= 13'h0000;
      end else begin
         SPREAD_ON <= spread_act;
         SPREAD_SPAN <= span_reg;
         if (!spread_act) begin
            ss_cnt_reg <= 13'h0000;
            SPREAD_MOD_UP <= 1'b0;
         end else if (ss_cnt_reg == SSMOD_LAST[12:0]) begin
            ss_cnt_reg <= 13'h0000;
            SPREAD_MOD_UP <= ~SPREAD_MOD_UP;
         end else begin
            ss_cnt_reg <= ss_cnt_reg + 13'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // hf clock sampled on MCLK; 8 samples per period even at 24 MHz
   always @(posedge MCLK) begin
      if (!RST_N) begin
         hf1_reg <= 1'b0;
         hf2_reg <= 1'b0;
         hf3_reg <= 1'b0;
      end else begin
         hf1_reg <= HF_CLK_IN;
         hf2_reg <= hf1_reg;
         hf3_reg <= hf2_reg;
      end
   end

   // divide by 8: toggle every fourth rising edge for a square output
   always @(posedge MCLK) begin
      if (!RST_N) begin
         hf_cnt_reg <= 2'h0;
         div_reg <= 1'b0;
      end else if (hf_rise) begin
         hf_cnt_reg <= hf_cnt_reg + 2'h1;
         if (hf_cnt_reg == HF_HALF_LAST[1:0])
            div_reg <= ~div_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sync validity must last a few control ticks, loss is immediate
   always @(posedge MCLK) begin
      if (!RST_N) begin
         db_cnt_reg <= 2'h0;
         sync_valid_reg <= 1'b0;
      end else if (!period_ok || !sync_en_eff) begin
         db_cnt_reg <= 2'h0;
         sync_valid_reg <= 1'b0;
      end else if (TICK_100K && !sync_valid_reg) begin
         if (db_cnt_reg == DB_TICKS[1:0] - 2'h1)
            sync_valid_reg <= 1'b1;
         else
            db_cnt_reg <= db_cnt_reg + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // source selection
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (EXT_SYNC_FUSE_ENABLE)
               state_next = ST_INT;
         end
         ST_INT: begin
            if (!EXT_SYNC_FUSE_ENABLE)
               state_next = ST_OFF;
            else if (!fault_flag_reg && sync_valid_reg && sync_en_eff)
               state_next = ST_EXT;
         end
         ST_EXT: begin
            if (!EXT_SYNC_FUSE_ENABLE)
               state_next = ST_OFF;
            else if (fault_state || !sync_en_eff)
               state_next = ST_INT;
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   always @(posedge MCLK) begin
      if (!RST_N) begin
         state_reg <= ST_OFF;
         PLL_ON <= 1'b0;
         PLL_SRC_EXT <= 1'b0;
      end else begin
         state_reg <= state_next;
         PLL_ON <= (state_next != ST_OFF);
         PLL_SRC_EXT <= (state_next == ST_EXT);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // switching clock and its copy on the sync output pin
   always @* begin
      if (state_reg == ST_EXT)
         sw_clk_next = ext_lvl;
      else
         sw_clk_next = div_reg;
   end

   always @(posedge MCLK) begin
      if (!RST_N) begin
         SW_CLK <= 1'b0;
         SYNC_CLOCK_OUT <= 1'b0;
      end else begin
         SW_CLK <= sw_clk_next;
         SYNC_CLOCK_OUT <= out_en_reg & sw_clk_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sticky flags: write one clears, a same-cycle event wins
   always @(posedge MCLK) begin
      if (!RST_N) begin
         settled_flag_reg <= 1'b0;
         fault_flag_reg <= 1'b0;
      end else begin
         if (settle_pulse)
            settled_flag_reg <= 1'b1;
         else if (wr_flag && WDATA[`PCM_FLAG_SETTLED])
            settled_flag_reg <= 1'b0;
         if (fault_state)
            fault_flag_reg <= 1'b1;
         else if (wr_flag && WDATA[`PCM_FLAG_FAULT])
            fault_flag_reg <= 1'b0;
      end
   end

   // active-low interrupt from unmasked flags
   always @(posedge MCLK) begin
      if (!RST_N)
         IRQ_OUT_N <= 1'b1;
      else
         IRQ_OUT_N <= ~((settled_flag_reg & ~mask_reg[0]) | (fault_flag_reg & ~mask_reg[1]));
   end

   ////////////////////////////////////////////////////////////////////
   // read port: data stand one cycle after the strobe, zero otherwise
   always @(posedge MCLK) begin
      if (!RST_N) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            `PCM_ADDR_CTRL: RDATA <= {out_en_reg, band_reg, span_reg, spread_en_reg, trim_reg};
            `PCM_ADDR_SYNC: RDATA <= {6'h00, EXT_SYNC_FUSE_ENABLE, sync_en_reg};
            `PCM_ADDR_STAT: RDATA <= {ext_sel, fault_state, sync_valid_reg,
                                      (cur_idx_reg != tgt_idx_reg), code_of(cur_idx_reg)};
            `PCM_ADDR_FLAG: RDATA <= {6'h00, fault_flag_reg, settled_flag_reg};
            `PCM_ADDR_MASK: RDATA <= {6'h00, mask_reg};
            default: RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

endmodule

// ### dv/pcm_clock_mgmt_properties.sv
/*
 * port checker of the clock manager, bound to its top module.
 * assumes a valid fuse trim code and static fuse defaults.
 */
`timescale 1ns/1ps
module pcm_clock_mgmt_properties (
   input wire MCLK,
   input wire RST_N,
   input wire EXT_SYNC_FUSE_ENABLE,
   input wire [3:0] HF_CLOCK_TRIM,
   input wire SPREAD_ON,
   input wire SPREAD_MOD_UP,
   input wire PLL_ON,
   input wire PLL_SRC_EXT,
   input wire SW_CLK,
   input wire SYNC_CLOCK_OUT,
   input wire TICK_100K
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   // position of a code on the linear 16..24 MHz scale
   function [3:0] rank(input [3:0] c);
      rank = c[3] ? c - 4'h9 : c + 4'h4;
   endfunction

   // cycles since the last tick; phase is free until the first one
   reg [11:0] gap_reg;
   reg seen_reg;
   always @(posedge MCLK) begin
      if (!RST_N) begin
         gap_reg <= 12'h000;
         seen_reg <= 1'b0;
      end else if (TICK_100K) begin
         gap_reg <= 12'h001;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   a_tick_period: assert property (seen_reg |-> TICK_100K == (gap_reg == 12'h7d0))
      else $error("tick spacing wrong");
   a_trim_legal: assert property (HF_CLOCK_TRIM <= 4'h4 || (HF_CLOCK_TRIM >= 4'h9 && HF_CLOCK_TRIM <= 4'hc))
      else $error("applied trim code unused");
   a_trim_one_step: assert property ($changed(HF_CLOCK_TRIM) |->
      rank(HF_CLOCK_TRIM) == rank($past(HF_CLOCK_TRIM)) + 4'h1 || rank(HF_CLOCK_TRIM) + 4'h1 == rank($past(HF_CLOCK_TRIM)))
      else $error("trim moved more than one step");
   a_trim_frozen: assert property ((SPREAD_ON || PLL_SRC_EXT) [*3] |-> $stable(HF_CLOCK_TRIM))
      else $error("trim retuned while held");
   a_ext_no_spread: assert property (PLL_SRC_EXT |-> !SPREAD_ON)
      else $error("spread on with external clock");
   a_mod_idle: assert property (!SPREAD_ON [*2] |-> !SPREAD_MOD_UP)
      else $error("modulation runs with spread off");
   a_pll_fuse_off: assert property (!EXT_SYNC_FUSE_ENABLE [*3] |-> !PLL_ON && !PLL_SRC_EXT)
      else $error("pll active with fuse sync off");
   a_pll_fuse_on: assert property (EXT_SYNC_FUSE_ENABLE [*3] |-> PLL_ON)
      else $error("pll off with fuse sync on");
   a_ext_needs_pll: assert property (PLL_SRC_EXT |-> PLL_ON)
      else $error("external source without pll");
   a_out_gated: assert property (SYNC_CLOCK_OUT |-> SW_CLK)
      else $error("sync output not following switch clock");

   c_trim_moves: cover property ($changed(HF_CLOCK_TRIM));
   c_ext_taken: cover property ($rose(PLL_SRC_EXT));
   c_mod_turns: cover property ($rose(SPREAD_MOD_UP));
endmodule

bind pcm_clock_mgmt pcm_clock_mgmt_properties chk_u (
   .MCLK(MCLK), .RST_N(RST_N), .EXT_SYNC_FUSE_ENABLE(EXT_SYNC_FUSE_ENABLE),
   .HF_CLOCK_TRIM(HF_CLOCK_TRIM), .SPREAD_ON(SPREAD_ON), .SPREAD_MOD_UP(SPREAD_MOD_UP),
   .PLL_ON(PLL_ON), .PLL_SRC_EXT(PLL_SRC_EXT), .SW_CLK(SW_CLK),
   .SYNC_CLOCK_OUT(SYNC_CLOCK_OUT), .TICK_100K(TICK_100K)
);

// ### dv/pcm_sync_source.sv
/*
 * external sync clock source facing the clock manager pin.
 * assumes a 1 ns time unit and a half period set by the bench.
 */
`timescale 1ns/1ps
module pcm_sync_source (
   input wire run,
   input wire [15:0] half_ns,
   output reg sync_pin
);
   // idle pin sits low, as the pull-down would leave it
   initial sync_pin = 1'b0;
   always begin
      if (run) begin
         #(half_ns) sync_pin = ~sync_pin;
      end else begin
         sync_pin = 1'b0;
         #1;
      end
   end
endmodule

// ### dv/pcm_clock_mgmt_bench.sv
/*
 * bench of the clock manager: register master, 20 MHz oscillator,
 * sync source partner, one task per scenario.
 * assumes the port checker is bound from its own file.
 */
`timescale 1ns/1ps
`include "pcm_clock_map.vh"
module pcm_clock_mgmt_bench;
   reg MCLK = 1'b0;
   reg RST_N = 1'b0;
   reg [7:0] ADDR = 8'h00;
   reg [7:0] WDATA = 8'h00;
   reg WR = 1'b0;
   reg RD = 1'b0;
   reg HF_CLK_IN = 1'b0;
   reg EXT_SYNC_FUSE_ENABLE = 1'b1;
   reg sync_run = 1'b0;
   reg [15:0] sync_half = 16'h00c8;
   reg [7:0] rv;
   integer n_errors;
   integer n_tests;
   integer n;
   integer a;
   integer b;
   wire [7:0] RDATA;
   wire [3:0] HF_CLOCK_TRIM;
   wire EXT_SYNC_IN, SPREAD_ON, SPREAD_SPAN, SPREAD_MOD_UP, PLL_ON, PLL_SRC_EXT;
   wire SW_CLK, SYNC_CLOCK_OUT, TICK_100K, IRQ_OUT_N;

   // 200 MHz system clock, 20 MHz oscillator
   always #2.5 MCLK = ~MCLK;
   always #25 HF_CLK_IN = ~HF_CLK_IN;

   // fuse trim 1, span 1, sync out 1, sync fuse enable 1, the rest 0
   pcm_clock_mgmt dut_u (
      .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .HF_CLOCK_TRIM_FUSE(4'h1), .SPREAD_ENABLE_FUSE_DEFAULT(1'b0), .SPREAD_SPAN_FUSE_DEFAULT(1'b1),
      .EXT_SYNC_FUSE_ENABLE(EXT_SYNC_FUSE_ENABLE), .SYNC_BAND_FUSE_DEFAULT(1'b0),
      .SYNC_CLOCK_OUT_FUSE_DEFAULT(1'b1), .HF_CLK_IN(HF_CLK_IN), .EXT_SYNC_IN(EXT_SYNC_IN),
      .HF_CLOCK_TRIM(HF_CLOCK_TRIM), .SPREAD_ON(SPREAD_ON), .SPREAD_SPAN(SPREAD_SPAN),
      .SPREAD_MOD_UP(SPREAD_MOD_UP), .PLL_ON(PLL_ON), .PLL_SRC_EXT(PLL_SRC_EXT), .SW_CLK(SW_CLK),
      .SYNC_CLOCK_OUT(SYNC_CLOCK_OUT), .TICK_100K(TICK_100K), .IRQ_OUT_N(IRQ_OUT_N)
   );
   pcm_sync_source src_u (.run(sync_run), .half_ns(sync_half), .sync_pin(EXT_SYNC_IN));

   ////////////////////////////////////////////////////////////////////
   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   // every compare goes through here, four-state exact
   task chk(input [8*16-1:0] nm, input [15:0] exp, input [15:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask

   task tmo;
      begin
         n_errors = n_errors + 1;
         $display("mismatch wait expected done seen timeout");
         print_verdict;
      end
   endtask

   task wr(input [7:0] ad, input [7:0] d);
      begin
         @(posedge MCLK);
         ADDR <= ad;
         WDATA <= d;
         WR <= 1'b1;
         @(posedge MCLK);
         WR <= 1'b0;
      end
   endtask

   // data stands only in the cycle after the strobe
   task rd(input [7:0] ad);
      begin
         @(posedge MCLK);
         ADDR <= ad;
         RD <= 1'b1;
         @(posedge MCLK);
         RD <= 1'b0;
         @(negedge MCLK);
         rv = RDATA;
      end
   endtask

   // cycles until the trim (sel 0) or the modulation (sel 1) moves
   task wait_move(input sel);
      reg [3:0] t0;
      begin
         t0 = sel ? {3'h0, SPREAD_MOD_UP} : HF_CLOCK_TRIM;
         n = 0;
         while ((sel ? {3'h0, SPREAD_MOD_UP} : HF_CLOCK_TRIM) === t0 && n < 5000) begin
            @(negedge MCLK);
            n = n + 1;
         end
         if (n >= 5000) tmo;
      end
   endtask

   task wait_ext(input v, input integer lim);
      begin
         n = 0;
         while (PLL_SRC_EXT !== v && n < lim) begin
            @(negedge MCLK);
            n = n + 1;
         end
         if (n >= lim) tmo;
      end
   endtask

   // poll status until the sync input counts as valid
   task wait_valid;
      begin
         n = 0;
         rv = 8'h00;
         while (rv[5] !== 1'b1 && n < 4000) begin
            rd(`PCM_ADDR_STAT);
            n = n + 1;
         end
         if (n >= 4000) tmo;
      end
   endtask

   // rising edges of the switch clock and of the sync output
   task count_edges(input integer cyc);
      integer k;
      reg ps;
      reg po;
      begin
         a = 0;
         b = 0;
         ps = SW_CLK;
         po = SYNC_CLOCK_OUT;
         for (k = 0; k < cyc; k = k + 1) begin
            @(negedge MCLK);
            a = a + (SW_CLK & ~ps);
            b = b + (SYNC_CLOCK_OUT & ~po);
            ps = SW_CLK;
            po = SYNC_CLOCK_OUT;
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   task t_reset;
      begin
         repeat (4) @(posedge MCLK);
         RST_N <= 1'b1;
         rd(`PCM_ADDR_CTRL);
         chk("ctrl", 8'ha1, rv);
         chk("trim", 4'h1, HF_CLOCK_TRIM);
         rd(`PCM_ADDR_SYNC);
         chk("sync", 8'h03, rv);
         rd(8'h07);
         chk("unmapped", 8'h00, rv);
         rd(`PCM_ADDR_FLAG);
         chk("fault flag", 8'h02, rv);
         chk("irq", 1'b0, IRQ_OUT_N);
         chk("pll on", 1'b1, PLL_ON);
      end
   endtask

   // walk 1 -> 9 passes 0, c, b, a with 1040 cycles (5.2 us) between
   task t_walk;
      integer i;
      begin
         wr(`PCM_ADDR_MASK, 8'h02);
         wr(`PCM_ADDR_FLAG, 8'h03);
         wr(`PCM_ADDR_CTRL, 8'ha9);
         for (i = 0; i < 5; i = i + 1) begin
            wait_move(1'b0);
            chk("walk step", (i == 0) ? 4'h0 : 4'hd - i[3:0], HF_CLOCK_TRIM);
            if (i > 0) chk("dwell", 16'h0410, n[15:0]);
         end
         repeat (2) @(negedge MCLK);
         chk("settled irq", 1'b0, IRQ_OUT_N);
         wr(`PCM_ADDR_FLAG, 8'h01);
         repeat (2) @(negedge MCLK);
         chk("irq cleared", 1'b1, IRQ_OUT_N);
         wr(`PCM_ADDR_MASK, 8'h03);
         wr(`PCM_ADDR_CTRL, 8'haa);
         wait_move(1'b0);
         chk("one step", 4'ha, HF_CLOCK_TRIM);
         repeat (2) @(negedge MCLK);
         chk("masked irq", 1'b1, IRQ_OUT_N);
         rd(`PCM_ADDR_FLAG);
         chk("settled flag", 8'h01, rv & 8'h01);
      end
   endtask

   task t_unused;
      integer i;
      begin
         for (i = 5; i < 16; i = i + 1) begin
            if (i < 9 || i > 12) begin
               wr(`PCM_ADDR_CTRL, {4'ha, i[3:0]});
               repeat (4) @(negedge MCLK);
               chk("kept trim", 4'ha, HF_CLOCK_TRIM);
            end
         end
         rd(`PCM_ADDR_CTRL);
         chk("ctrl target", 8'haa, rv);
      end
   endtask

   // 20 MHz / 8 gives 100 edges in 8000 cycles
   task t_out;
      begin
         count_edges(8000);
         chk("hf div", 1'b1, a >= 99 && a <= 101);
         chk("out copy", 1'b1, b >= a - 1 && b <= a + 1);
         wr(`PCM_ADDR_CTRL, 8'h2a);
         count_edges(2000);
         chk("out rises", 16'h0000, b[15:0]);
         wr(`PCM_ADDR_CTRL, 8'haa);
      end
   endtask

   task t_spread;
      begin
         wr(`PCM_ADDR_CTRL, 8'hba);
         repeat (4) @(negedge MCLK);
         chk("spread held", 1'b0, SPREAD_ON);
         wr(`PCM_ADDR_SYNC, 8'h00);
         repeat (4) @(negedge MCLK);
         chk("spread on", 1'b1, SPREAD_ON);
         chk("span wide", 1'b1, SPREAD_SPAN);
         wait_move(1'b1);
         wait_move(1'b1);
         chk("mod half", 16'h1046, n[15:0]);
         wr(`PCM_ADDR_CTRL, 8'hbc);
         repeat (2200) @(negedge MCLK);
         chk("frozen trim", 4'ha, HF_CLOCK_TRIM);
         wr(`PCM_ADDR_CTRL, 8'h9a);
         repeat (4) @(negedge MCLK);
         chk("span narrow", 1'b0, SPREAD_SPAN);
         wr(`PCM_ADDR_CTRL, 8'haa);
         repeat (4) @(negedge MCLK);
         chk("spread off", 1'b0, SPREAD_ON);
         chk("mod idle", 1'b0, SPREAD_MOD_UP);
         wr(`PCM_ADDR_SYNC, 8'h01);
      end
   endtask

   task t_sync;
      begin
         wr(`PCM_ADDR_CTRL, 8'ha0);
         sync_half <= 16'h00c8;
         sync_run <= 1'b1;
         wait_valid;
         chk("fault state", 1'b0, rv[6]);
         chk("ext early", 1'b0, PLL_SRC_EXT);
         wr(`PCM_ADDR_FLAG, 8'h02);
         wait_ext(1'b1, 20);
         sync_half <= 16'h0064;
         wait_ext(1'b0, 200);
         rd(`PCM_ADDR_STAT);
         chk("fault set", 1'b1, rv[6]);
         wr(`PCM_ADDR_MASK, 8'h01);
         repeat (3) @(negedge MCLK);
         chk("fault irq", 1'b0, IRQ_OUT_N);
         wr(`PCM_ADDR_CTRL, 8'he0);
         sync_half <= 16'h04e2;
         wait_valid;
         wr(`PCM_ADDR_FLAG, 8'h02);
         wait_ext(1'b1, 20);
         sync_run <= 1'b0;
         wait_ext(1'b0, 2000);
         @(posedge MCLK);
         EXT_SYNC_FUSE_ENABLE <= 1'b0;
         count_edges(8000);
         chk("pll off", 1'b0, PLL_ON);
         chk("internal div", 1'b1, a >= 99 && a <= 101);
      end
   endtask

   initial begin
      n_errors = 0;
      n_tests = 0;
      t_reset;
      t_walk;
      t_unused;
      t_out;
      t_spread;
      t_sync;
      print_verdict;
   end
endmodule
